// >>> rng_cond_merge.sv
// bitwise conditional-write merge: only bits whose current value equals
// the compare value take the new data.
// assumes nothing beyond combinational use by the register block.
`timescale 1ns/1ps

module rng_cond_merge
  import rng_pkg::*;
(
  input wire logic [`RNG_DATA_W-1:0] curBits,
  input wire logic [`RNG_DATA_W-1:0] cmpBits,
  input wire logic [`RNG_DATA_W-1:0] newBits,
  output logic [`RNG_DATA_W-1:0] mergedBits
);

  logic [`RNG_DATA_W-1:0] matchBits;

  // ---------------------------------------------------------------
  // merge
  // ---------------------------------------------------------------
  // a bit that changed since software last sampled it is left alone
  assign matchBits = ~(curBits ^ cmpBits);
  assign mergedBits = (newBits & matchBits) | (curBits & ~matchBits);

endmodule

// >>> rng_map.svh
// register map, field positions and reset values of the ring engine
// mode, revision and compare registers.
// assumes a 9-bit control bus address whose top bit, when clear, selects the
// conditional-write path.
`ifndef RNG_MAP_SVH
`define RNG_MAP_SVH

`define RNG_ADDR_W 9
`define RNG_DATA_W 8
`define RNG_CBA_BIT 8
`define RNG_OFS_MODE2 9'h005
`define RNG_OFS_REV 9'h007
`define RNG_OFS_CMP 9'h008
`define RNG_OFS_LATCH 8'h09
`define RNG_BIT_ADDRESS_FLAG_INHIBIT_ENABLE 4
`define RNG_BIT_LLC 3
`define RNG_BIT_SMT 2
`define RNG_BIT_BRIDGE_OPTION_SELECT 0
`define RNG_MODE2_MASK 8'h1D
`define RNG_RST_BYTE 8'h00
`define RNG_REVISION_DEF 8'h5A

`endif

// >>> rng_pkg.sv
// types shared by the ring engine register block.
// assumes rng_map.svh is on the include path.
`include "rng_map.svh"

package rng_pkg;

  typedef struct packed {
    logic [`RNG_DATA_W-1:0] mode2;
    logic [`RNG_DATA_W-1:0] compare;
    logic [`RNG_DATA_W-1:0] latch;
    logic [`RNG_DATA_W-1:0] rdata;
    logic addrFlag;
    logic macSat;
    logic copyFrame;
    logic setIndicators;
    logic countFrame;
  } rng_state_type;

endpackage

// >>> rng_regs.sv
// ring engine mode-two, revision, compare and conditional event latch
// registers, with the address flag gate, token capture routing and
// group copy decision that the mode bits steer.
// assumes a register master that strobes for one cycle and signals that
// are synchronous to clk.
`timescale 1ns/1ps

module rng_regs
  import rng_pkg::*;
#(
  parameter logic [`RNG_DATA_W-1:0] REVISION = `RNG_REVISION_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic masterReset,
  input wire logic [`RNG_ADDR_W-1:0] regAddr,
  input wire logic [`RNG_DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [`RNG_DATA_W-1:0] regRdata,
  input wire logic [`RNG_DATA_W-1:0] eventIn,
  input wire logic addressFlagIn,
  input wire logic addressFlagInhibitPin,
  output logic addressRecognitionFlag,
  input wire logic tokenCaptureFromSi,
  input wire logic outputAFromSi,
  output logic tokenCaptureSignal,
  input wire logic frameStrobe,
  input wire logic fcIsLlc,
  input wire logic fcIsSmtMac,
  input wire logic destGroupBit,
  input wire logic addressMatch,
  output logic copyFrame,
  output logic setIndicators,
  output logic countFrame
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic hitFull(input logic [`RNG_ADDR_W-1:0] a,
                                   input logic [`RNG_ADDR_W-1:0] ofs);
    hitFull = (a == ofs);
  endfunction

  function automatic logic hitLatch(input logic [`RNG_ADDR_W-1:0] a);
    hitLatch = (a[`RNG_CBA_BIT-1:0] == `RNG_OFS_LATCH);
  endfunction

  rng_state_type cur_ff;
  rng_state_type nxt_state;
  logic [`RNG_DATA_W-1:0] mergedLatch;
  logic condWrite;
  logic groupHit;
  logic address_flag_inhibit_enable;
  logic llcEn;
  logic smtEn;
  logic bridge_option_select;

  assign address_flag_inhibit_enable = cur_ff.mode2[`RNG_BIT_ADDRESS_FLAG_INHIBIT_ENABLE];
  assign llcEn = cur_ff.mode2[`RNG_BIT_LLC];
  assign smtEn = cur_ff.mode2[`RNG_BIT_SMT];
  assign bridge_option_select = cur_ff.mode2[`RNG_BIT_BRIDGE_OPTION_SELECT];
  assign condWrite = ~regAddr[`RNG_CBA_BIT];

  rng_cond_merge u_merge (
    .curBits(cur_ff.latch),
    .cmpBits(cur_ff.compare),
    .newBits(regWdata),
    .mergedBits(mergedLatch)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = cur_ff;
    nxt_state.rdata = `RNG_RST_BYTE;
    // mode-two, plain write, reserved bits never stored
    if (regWrite && hitFull(regAddr, `RNG_OFS_MODE2)) begin
      nxt_state.mode2 = regWdata & `RNG_MODE2_MASK;
    end
    if (masterReset) begin
      nxt_state.mode2 = `RNG_RST_BYTE;
    end
    // compare register: direct write or latch snapshot
    if (regWrite && hitFull(regAddr, `RNG_OFS_CMP)) begin
      nxt_state.compare = regWdata;
    end
    if (regRead && hitLatch(regAddr)) begin
      nxt_state.compare = cur_ff.latch;
    end
    // event latch; a new event wins over a clearing write
    if (regWrite && hitLatch(regAddr)) begin
      if (condWrite) begin
        nxt_state.latch = mergedLatch | eventIn;
      end else begin
        nxt_state.latch = regWdata | eventIn;
      end
    end else begin
      nxt_state.latch = cur_ff.latch | eventIn;
    end
    // read data, one cycle after the strobe
    if (regRead) begin
      if (hitFull(regAddr, `RNG_OFS_MODE2)) begin
        nxt_state.rdata = cur_ff.mode2;
      end else if (hitFull(regAddr, `RNG_OFS_REV)) begin
        nxt_state.rdata = REVISION;
      end else if (hitFull(regAddr, `RNG_OFS_CMP)) begin
        nxt_state.rdata = cur_ff.compare;
      end else if (hitLatch(regAddr)) begin
        nxt_state.rdata = cur_ff.latch;
      end else begin
        nxt_state.rdata = `RNG_RST_BYTE;
      end
    end
    // address flag gate; pin only matters with the enable set
    nxt_state.addrFlag = addressFlagIn &
                         ~(address_flag_inhibit_enable & addressFlagInhibitPin);
    // token capture routing for bridging
    nxt_state.macSat = bridge_option_select ? outputAFromSi : tokenCaptureFromSi;
    // frame copy decision, one pulse per frame strobe
    nxt_state.copyFrame = frameStrobe & (addressMatch | groupHit);
    nxt_state.setIndicators = frameStrobe & addressMatch;
    nxt_state.countFrame = frameStrobe & addressMatch;
  end

  assign groupHit = destGroupBit &
                    ((llcEn & fcIsLlc) | (smtEn & fcIsSmtMac));

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // mode-two is assumed stable during ring operation, so no guard
  // against mid-frame changes of the copy enables is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_state;
    end
  end

  assign regRdata = cur_ff.rdata;
  assign addressRecognitionFlag = cur_ff.addrFlag;
  assign tokenCaptureSignal = cur_ff.macSat;
  assign copyFrame = cur_ff.copyFrame;
  assign setIndicators = cur_ff.setIndicators;
  assign countFrame = cur_ff.countFrame;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_latchRead;
    regRead && hitLatch(regAddr);
  endsequence

  sequence s_cmpLoaded;
    cur_ff.compare == $past(cur_ff.latch);
  endsequence

  a_mode_master_clear: assert property (
    masterReset |=> cur_ff.mode2 == `RNG_RST_BYTE)
    else $error("mode two not cleared by master reset");

  a_flag_pin_ignored: assert property (
    !address_flag_inhibit_enable |=> addressRecognitionFlag == $past(addressFlagIn))
    else $error("inhibit pin acted while disabled");

  a_flag_pin_blocks: assert property (
    (address_flag_inhibit_enable && addressFlagInhibitPin) |=> !addressRecognitionFlag)
    else $error("address flag passed while inhibited");

  a_llc_group_copy: assert property (
    (frameStrobe && llcEn && fcIsLlc && destGroupBit) |=> copyFrame)
    else $error("llc group frame not copied");

  a_smt_group_copy: assert property (
    (frameStrobe && smtEn && fcIsSmtMac && destGroupBit) |=> copyFrame)
    else $error("smt group frame not copied");

  a_group_no_count: assert property (
    (frameStrobe && !addressMatch) |=> !setIndicators && !countFrame)
    else $error("group-only copy touched indicators or counters");

  a_sat_route: assert property (
    1'b1 |=> tokenCaptureSignal == ($past(bridge_option_select) ? $past(outputAFromSi)
                                     : $past(tokenCaptureFromSi)))
    else $error("token capture routing wrong");

  a_mode_readback: assert property (
    (regWrite && hitFull(regAddr, `RNG_OFS_MODE2) && !masterReset)
    ##1 (regRead && hitFull(regAddr, `RNG_OFS_MODE2))
    |=> regRdata == ($past(regWdata, 2) & `RNG_MODE2_MASK))
    else $error("mode two readback mismatch");

  a_rev_read: assert property (
    (regRead && hitFull(regAddr, `RNG_OFS_REV)) |=> regRdata == REVISION)
    else $error("revision read wrong");

  a_cond_write: assert property (
    (regWrite && hitLatch(regAddr) && condWrite) |=>
    cur_ff.latch == ($past(mergedLatch) | $past(eventIn)))
    else $error("conditional write merge wrong");

  a_cmp_snapshot: assert property (
    s_latchRead |=> s_cmpLoaded)
    else $error("compare not loaded on latch read");

endmodule

// >>> test_rng_regs.sv
// self-checking bench for the ring engine mode-two, revision, compare
// and event latch registers; it drives every port of rng_regs itself.
// assumes rng_map.svh on the include path and rng_pkg compiled first.
`timescale 1ns/1ps
`include "rng_map.svh"

module test_rng_regs import rng_pkg::*;;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  logic clk = 1'b0, rst = 1'b1, masterReset = 1'b0;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic [8:0] regAddr = 9'h000;
  logic [7:0] regWdata = 8'h00, eventIn = 8'h00, regRdata, m, d, c, w, e;
  logic [8:0] v = 9'h000;
  logic addressRecognitionFlag, tokenCaptureSignal;
  logic copyFrame, setIndicators, countFrame;
  logic [4:0] x;
  integer seed, err_total = 0, num_checks = 0, cycleCnt = 0;

  always #4 clk = ~clk;

  rng_regs #(.REVISION(REV)) u_rng_regs (.clk(clk), .rst(rst),
    .masterReset(masterReset), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .eventIn(eventIn), .addressFlagIn(v[0]),
    .addressFlagInhibitPin(v[1]),
    .addressRecognitionFlag(addressRecognitionFlag),
    .tokenCaptureFromSi(v[2]), .outputAFromSi(v[3]),
    .tokenCaptureSignal(tokenCaptureSignal), .frameStrobe(v[4]),
    .fcIsLlc(v[5]), .fcIsSmtMac(v[6]), .destGroupBit(v[7]),
    .addressMatch(v[8]), .copyFrame(copyFrame),
    .setIndicators(setIndicators), .countFrame(countFrame));

  // ----------------------------------------------------------------
  // bus tasks and comparisons
  // ----------------------------------------------------------------
  task tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [7:0] ex, input logic [7:0] g);
    num_checks++;
    if (g !== ex) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, ex, g);
    end
  endtask

  task wr(input logic [8:0] a, input logic [7:0] dat);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= dat;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rdchk(input logic [8:0] a, input logic [7:0] ex);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk($sformatf("read %h", a), ex, regRdata);
  endtask

  task pulseMaster();
    @(posedge clk);
    masterReset <= 1'b1;
    @(posedge clk);
    masterReset <= 1'b0;
  endtask

  // flag, token capture, copy, indicators, count one cycle after inputs
  function logic [4:0] expDp(input logic [7:0] md, input logic [8:0] in);
    logic grpHit;
    grpHit = in[7] & ((md[3] & in[5]) | (md[2] & in[6]));
    expDp = {in[0] & ~(md[4] & in[1]), md[0] ? in[3] : in[2],
      in[4] & (in[8] | grpHit), in[4] & in[8], in[4] & in[8]};
  endfunction

  // ----------------------------------------------------------------
  // hang guard: the sequence needs well under 3000 cycles
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cycleCnt++;
    if (cycleCnt == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    seed = 32'hB5FD;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(9'h005, 8'h00);
    rdchk(9'h007, REV);
    rdchk(9'h008, 8'h00);
    wr(9'h005, 8'hFF);
    rdchk(9'h005, 8'h1D);
    wr(9'h007, ~REV);
    rdchk(9'h007, REV);
    rdchk(9'h00A, 8'h00);
    pulseMaster();
    rdchk(9'h005, 8'h00);
    for (int i = 0; i < 12; i++) begin
      pulseMaster();
      m = $random(seed);
      wr(9'h005, m);
      repeat (10) begin
        @(posedge clk);
        v <= $random(seed);
        @(posedge clk);
        #1 x = expDp(m, v);
        chk("flag", {7'h00, x[4]}, {7'h00, addressRecognitionFlag});
        chk("token", {7'h00, x[3]}, {7'h00, tokenCaptureSignal});
        chk("frame", {5'h00, x[2:0]},
          {5'h00, copyFrame, setIndicators, countFrame});
      end
    end
    // a frame seen only through the group enables: copied, not counted
    wr(9'h005, 8'h0C);
    @(posedge clk);
    v <= 9'h0F0;
    @(posedge clk);
    #1 chk("group", 8'h04,
      {5'h00, copyFrame, setIndicators, countFrame});
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      c = $random(seed);
      w = $random(seed);
      wr(9'h109, d);
      wr(9'h008, c);
      rdchk(9'h008, c);
      wr(9'h009, w);
      e = (w & ~(d ^ c)) | (d & (d ^ c));
      rdchk(9'h109, e);
      rdchk(9'h008, e);
    end
    @(posedge clk);
    eventIn <= 8'h80;
    @(posedge clk);
    eventIn <= 8'h00;
    rdchk(9'h109, e | 8'h80);
    tally_and_finish();
  end
endmodule
